//--- verilog/ppfs_pkg.sv
package ppfs_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_PORT_A_SELECT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_PORT_A_SELECT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_PORT_B_SELECT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_PORT_C_SELECT_LOW  = 8'h0C;
  localparam logic [7:0] ADDR_PORT_C_SELECT_HIGH = 8'h10;
  localparam logic [7:0] ADDR_PORT_A_DATA        = 8'h14;
  localparam logic [7:0] ADDR_PORT_B_DATA        = 8'h18;
  localparam logic [7:0] ADDR_PORT_C_DATA        = 8'h1C;
  localparam logic [7:0] ADDR_PORT_A_DIR         = 8'h20;
  localparam logic [7:0] ADDR_PORT_B_DIR         = 8'h24;
  localparam logic [7:0] ADDR_PORT_C_DIR         = 8'h28;
  localparam logic [7:0] ADDR_WAKE_ENABLE        = 8'h2C;
  localparam logic [7:0] ADDR_BIT_OP             = 8'h30;
  localparam logic [7:0] ADDR_STATUS             = 8'h34;

  // Writable bit masks
  localparam logic [7:0] MASK_PORT_A_SELECT_LOW  = 8'hCC;
  localparam logic [7:0] MASK_PORT_A_SELECT_HIGH = 8'h03;

  // Field positions (low bit of each 2-bit code)
  localparam int POS_A3_SEL = 6;
  localparam int POS_A1_SEL = 2;
  localparam int POS_A4_SEL = 0;

  // Alternate function code
  localparam logic [1:0] SEL_ALT = 2'h3;

  // Reset values
  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [7:0] RST_DATA   = 8'hFF;
  localparam logic [7:0] RST_DIR    = 8'hFF;
  localparam logic [7:0] RST_WAKE   = 8'h00;

  // Bit operation word: [3:0] register index, [6:4] bit, [8] set/clear
  localparam int BITOP_REG_LSB = 0;
  localparam int BITOP_BIT_LSB = 4;
  localparam int BITOP_SET_POS = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPFS_IDLE   = 2'h0,
    PPFS_READ   = 2'h1,
    PPFS_MODIFY = 2'h2
  } ppfs_rmw_e;

endpackage

//--- verilog/ppfs_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
// One 8-bit port: latch, direction, alternate routing, pin level
interface ppfs_pin_if;
  logic [7:0] data_latch;
  logic [7:0] dir;
  logic [7:0] alt_sel;
  logic [7:0] alt_out;
  logic [7:0] pin_sync;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] read_value;

  modport ctrl (output data_latch, dir, alt_sel, alt_out, pin_sync,
                input pin_out, pin_oe_n, read_value);
  modport pad  (input data_latch, dir, alt_sel, alt_out, pin_sync,
                output pin_out, pin_oe_n, read_value);
endinterface
`default_nettype wire

//--- verilog/ppfs_port_pad.sv
`timescale 1ns/100ps
`default_nettype none
module ppfs_port_pad (
  ppfs_pin_if.pad p
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (p.alt_sel[i]) begin
        // Alternate function owns the pin; latch is held, not shown
        p.pin_out[i]  = p.alt_out[i]; // [R14]
        p.pin_oe_n[i] = 1'b0;
      end else begin
        p.pin_out[i]  = p.data_latch[i]; // [R8]
        p.pin_oe_n[i] = p.dir[i]; // [R11]
      end
      // Output pins read back the latch, inputs the pin
      p.read_value[i] = p.dir[i] ? p.pin_sync[i] : p.data_latch[i]; // [R11]
    end
  end
endmodule
`default_nettype wire

//--- verilog/ppfs_top.sv
// Notes on behaviour
// [R1] Code 11 routes A3 to timer compare
// [R2] Code 11 routes A1 to EL function
// [R3] Code 11 routes A4 to inverted compare
// [R4] Port B upper pins to LCD segments; only pins 5 to 7 are routed, pin 4 stays GPIO
// [R5] Port C upper pins to LCD segments
// [R6] Unimplemented port A select bits read zero
// [R7] Data and direction reset to ones
// [R8] New output drives latch value, high
// [R9] Bit set/clear is read-modify-write byte
// [R10] Falling edge on enabled A pin wakes
// [R11] Direction 1 input, 0 output; latch readback
// [R12] Wake only when GPIO and halted
// [R13] Software selects pin before enabling peripheral
// [R14] Alternate function drives pin, latch kept
// [R15] Selection registers reset to zero
`timescale 1ns/100ps
`default_nettype none
module ppfs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_a_in,
  output logic [7:0]       port_a_out,
  output logic [7:0]       port_a_oe_n,
  input  wire logic [7:0]  port_b_in,
  output logic [7:0]       port_b_out,
  output logic [7:0]       port_b_oe_n,
  input  wire logic [7:0]  port_c_in,
  output logic [7:0]       port_c_out,
  output logic [7:0]       port_c_oe_n,
  input  wire logic        timer_compare_out,
  input  wire logic        timer_compare_out_inverted,
  input  wire logic        el_function,
  input  wire logic [11:0] lcd_segment,
  input  wire logic        halted,
  output logic             wake_request
);

  typedef struct packed {
    logic                  aw_held;
    logic [7:0]            aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [7:0]            sel_a_low;
    logic [7:0]            sel_a_high;
    logic [7:0]            sel_b_high;
    logic [7:0]            sel_c_low;
    logic [7:0]            sel_c_high;
    logic [7:0]            data_a;
    logic [7:0]            data_b;
    logic [7:0]            data_c;
    logic [7:0]            dir_a;
    logic [7:0]            dir_b;
    logic [7:0]            dir_c;
    logic [7:0]            wake_en;
    ppfs_pkg::ppfs_rmw_e   rmw;
    logic [8:0]            bitop;
    logic [7:0]            rmw_byte;
    logic [7:0]            a_meta;
    logic [7:0]            a_sync;
    logic [7:0]            b_meta;
    logic [7:0]            b_sync;
    logic [7:0]            c_meta;
    logic [7:0]            c_sync;
    logic [7:0]            a_prev;
    logic                  wake;
  } ppfs_state_s;

  ppfs_state_s q;
  ppfs_state_s next_q;

  ppfs_pin_if pa ();
  ppfs_pin_if pb ();
  ppfs_pin_if pc ();

  ppfs_port_pad u_pad_a (
    .p (pa)
  );
  ppfs_port_pad u_pad_b (
    .p (pb)
  );
  ppfs_port_pad u_pad_c (
    .p (pc)
  );

  logic [7:0] alt_a;
  logic [7:0] alt_b;
  logic [7:0] alt_c;
  logic [7:0] gpio_a;

  always_comb begin
    alt_a = 8'h00;
    alt_a[3] = q.sel_a_low[ppfs_pkg::POS_A3_SEL +: 2]
               == ppfs_pkg::SEL_ALT; // [R1]
    alt_a[1] = q.sel_a_low[ppfs_pkg::POS_A1_SEL +: 2]
               == ppfs_pkg::SEL_ALT; // [R2]
    alt_a[4] = q.sel_a_high[ppfs_pkg::POS_A4_SEL +: 2]
               == ppfs_pkg::SEL_ALT; // [R3]
    for (int i = 0; i < 4; i++) begin
      alt_b[i]     = q.sel_b_high[2*i +: 2] == ppfs_pkg::SEL_ALT; // [R4]
      alt_b[i + 4] = 1'b0;
      alt_c[i]     = q.sel_c_low[2*i +: 2] == ppfs_pkg::SEL_ALT;
      alt_c[i + 4] = q.sel_c_high[2*i +: 2] == ppfs_pkg::SEL_ALT; // [R5]
    end
    // Pin 4 of port B has no segment behind it here
    alt_b[4] = q.sel_b_high[0 +: 2] == ppfs_pkg::SEL_ALT;
    alt_b[5] = q.sel_b_high[2 +: 2] == ppfs_pkg::SEL_ALT; // [R4]
    alt_b[6] = q.sel_b_high[4 +: 2] == ppfs_pkg::SEL_ALT; // [R4]
    alt_b[7] = q.sel_b_high[6 +: 2] == ppfs_pkg::SEL_ALT; // [R4]
    alt_b[3:0] = 4'h0;
    alt_b[4]   = 1'b0;
    gpio_a = ~alt_a;
  end

  assign pa.data_latch = q.data_a;
  assign pa.dir        = q.dir_a;
  assign pa.alt_sel    = alt_a;
  assign pa.alt_out    = {3'h0, timer_compare_out_inverted,
                          timer_compare_out, 1'b0, el_function, 1'b0};
  assign pa.pin_sync   = q.a_sync;

  assign pb.data_latch = q.data_b;
  assign pb.dir        = q.dir_b;
  assign pb.alt_sel    = alt_b;
  assign pb.alt_out    = {lcd_segment[11:9], 5'h00};
  assign pb.pin_sync   = q.b_sync;

  assign pc.data_latch = q.data_c;
  assign pc.dir        = q.dir_c;
  assign pc.alt_sel    = alt_c;
  assign pc.alt_out    = {lcd_segment[7:0]};
  assign pc.pin_sync   = q.c_sync;

  assign port_a_out  = pa.pin_out;
  assign port_a_oe_n = pa.pin_oe_n;
  assign port_b_out  = pb.pin_out;
  assign port_b_oe_n = pb.pin_oe_n;
  assign port_c_out  = pc.pin_out;
  assign port_c_oe_n = pc.pin_oe_n;

  // Register read mux, used by the bus and the bit-operation engine
  function automatic logic [8:0] read_reg(input logic [7:0] addr);
    logic [8:0] r;
    r = {1'b1, 8'h00};
    case (addr)
      ppfs_pkg::ADDR_PORT_A_SELECT_LOW:
        r[7:0] = q.sel_a_low & ppfs_pkg::MASK_PORT_A_SELECT_LOW; // [R6]
      ppfs_pkg::ADDR_PORT_A_SELECT_HIGH:
        r[7:0] = q.sel_a_high & ppfs_pkg::MASK_PORT_A_SELECT_HIGH; // [R6]
      ppfs_pkg::ADDR_PORT_B_SELECT_HIGH: r[7:0] = q.sel_b_high;
      ppfs_pkg::ADDR_PORT_C_SELECT_LOW:  r[7:0] = q.sel_c_low;
      ppfs_pkg::ADDR_PORT_C_SELECT_HIGH: r[7:0] = q.sel_c_high;
      ppfs_pkg::ADDR_PORT_A_DATA:        r[7:0] = pa.read_value; // [R11]
      ppfs_pkg::ADDR_PORT_B_DATA:        r[7:0] = pb.read_value;
      ppfs_pkg::ADDR_PORT_C_DATA:        r[7:0] = pc.read_value;
      ppfs_pkg::ADDR_PORT_A_DIR:         r[7:0] = q.dir_a;
      ppfs_pkg::ADDR_PORT_B_DIR:         r[7:0] = q.dir_b;
      ppfs_pkg::ADDR_PORT_C_DIR:         r[7:0] = q.dir_c;
      ppfs_pkg::ADDR_WAKE_ENABLE:        r[7:0] = q.wake_en;
      ppfs_pkg::ADDR_STATUS: r[7:0] = {6'h00, q.rmw != ppfs_pkg::PPFS_IDLE,
                                       q.wake};
      ppfs_pkg::ADDR_BIT_OP: r[7:0] = 8'h00;
      default:               r[8] = 1'b0;
    endcase
    return r;
  endfunction

  // Byte write into one register; shared by bus and read-modify-write
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] v);
    case (addr)
      ppfs_pkg::ADDR_PORT_A_SELECT_LOW:
        next_q.sel_a_low = v & ppfs_pkg::MASK_PORT_A_SELECT_LOW; // [R6]
      ppfs_pkg::ADDR_PORT_A_SELECT_HIGH:
        next_q.sel_a_high = v & ppfs_pkg::MASK_PORT_A_SELECT_HIGH; // [R6]
      ppfs_pkg::ADDR_PORT_B_SELECT_HIGH: next_q.sel_b_high = v;
      ppfs_pkg::ADDR_PORT_C_SELECT_LOW:  next_q.sel_c_low  = v;
      ppfs_pkg::ADDR_PORT_C_SELECT_HIGH: next_q.sel_c_high = v;
      ppfs_pkg::ADDR_PORT_A_DATA:        next_q.data_a     = v;
      ppfs_pkg::ADDR_PORT_B_DATA:        next_q.data_b     = v;
      ppfs_pkg::ADDR_PORT_C_DATA:        next_q.data_c     = v;
      ppfs_pkg::ADDR_PORT_A_DIR:         next_q.dir_a      = v;
      ppfs_pkg::ADDR_PORT_B_DIR:         next_q.dir_b      = v;
      ppfs_pkg::ADDR_PORT_C_DIR:         next_q.dir_c      = v;
      ppfs_pkg::ADDR_WAKE_ENABLE:        next_q.wake_en    = v;
      default: ;
    endcase
  endtask

  logic [8:0] rd_aw;
  logic [8:0] rd_bus;
  logic [8:0] rd_rmw;
  logic [7:0] rmw_addr;
  logic       rmw_hit;

  always_comb begin
    next_q   = q;
    rd_aw    = read_reg(q.aw_addr);
    rmw_addr = {2'h0, q.bitop[ppfs_pkg::BITOP_REG_LSB +: 4], 2'h0};
    rd_rmw   = read_reg(rmw_addr);
    rd_bus   = read_reg(s_axi_araddr);
    rmw_hit  = 1'b0;

    // Two-stage synchronisers on the pins
    next_q.a_meta = port_a_in;
    next_q.a_sync = q.a_meta;
    next_q.b_meta = port_b_in;
    next_q.b_sync = q.b_meta;
    next_q.c_meta = port_c_in;
    next_q.c_sync = q.c_meta;
    next_q.a_prev = q.a_sync;

    // Falling edge on an enabled GPIO pin while halted; a low pulse
    // shorter than one clock may be missed by the synchroniser
    if (halted) begin
      if (|(q.a_prev & ~q.a_sync & q.wake_en & gpio_a)) begin // [R10] [R12]
        next_q.wake = 1'b1; // [R10]
      end
    end else begin
      next_q.wake = 1'b0;
    end

    // Bit set/clear: whole byte read, bit changed, byte written back
    case (q.rmw)
      ppfs_pkg::PPFS_READ: begin
        // Input pins read their level, so the write-back copies that
        // level into the latch, as software on the device would see it
        next_q.rmw_byte = rd_rmw[7:0]; // [R9]
        next_q.rmw      = ppfs_pkg::PPFS_MODIFY;
      end
      ppfs_pkg::PPFS_MODIFY: begin
        next_q.rmw_byte[q.bitop[ppfs_pkg::BITOP_BIT_LSB +: 3]] =
          q.bitop[ppfs_pkg::BITOP_SET_POS];
        write_reg(rmw_addr, next_q.rmw_byte); // [R9]
        next_q.rmw = ppfs_pkg::PPFS_IDLE;
      end
      default: next_q.rmw = ppfs_pkg::PPFS_IDLE;
    endcase
    rmw_hit = q.rmw != ppfs_pkg::PPFS_IDLE;

    // AXI4-Lite write: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.w_held = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    // A bus write waits while a bit operation owns the registers, so the
    // two writers never meet in one cycle; this costs up to two cycles
    if (q.aw_held && q.w_held && !q.bvalid && !rmw_hit) begin
      next_q.aw_held = 1'b0;
      next_q.w_held  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = rd_aw[8] ? ppfs_pkg::RESP_OKAY
                                : ppfs_pkg::RESP_SLVERR;
      if (q.w_strb[0]) begin
        if (q.aw_addr == ppfs_pkg::ADDR_BIT_OP) begin
          next_q.bitop = q.w_data[8:0];
          next_q.rmw   = ppfs_pkg::PPFS_READ; // [R9]
        end else begin
          write_reg(q.aw_addr, q.w_data[7:0]);
        end
      end
      if (q.w_strb[1] && q.aw_addr == ppfs_pkg::ADDR_BIT_OP) begin
        next_q.bitop[ppfs_pkg::BITOP_SET_POS] = q.w_data[8];
      end
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    // AXI4-Lite read
    if (s_axi_arvalid && s_axi_arready) begin
      next_q.rvalid = 1'b1;
      next_q.rdata  = {24'h000000, rd_bus[7:0]};
      next_q.rresp  = rd_bus[8] ? ppfs_pkg::RESP_OKAY
                                : ppfs_pkg::RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
  end

  // Ready drops once an address or data word is held, which limits the
  // slave to one write in flight
  assign s_axi_awready = !q.aw_held;
  assign s_axi_wready  = !q.w_held;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign wake_request  = q.wake;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.sel_a_low  <= ppfs_pkg::RST_SELECT; // [R15]
      q.sel_a_high <= ppfs_pkg::RST_SELECT; // [R15]
      q.sel_b_high <= ppfs_pkg::RST_SELECT; // [R15]
      q.sel_c_low  <= ppfs_pkg::RST_SELECT; // [R15]
      q.sel_c_high <= ppfs_pkg::RST_SELECT; // [R15]
      // Latch starts high, so a pin turned to output before any data
      // write drives high
      q.data_a     <= ppfs_pkg::RST_DATA; // [R7]
      q.data_b     <= ppfs_pkg::RST_DATA; // [R7]
      q.data_c     <= ppfs_pkg::RST_DATA; // [R7]
      q.dir_a      <= ppfs_pkg::RST_DIR; // [R7]
      q.dir_b      <= ppfs_pkg::RST_DIR; // [R7]
      q.dir_c      <= ppfs_pkg::RST_DIR; // [R7]
      q.wake_en    <= ppfs_pkg::RST_WAKE;
      q.rmw        <= ppfs_pkg::PPFS_IDLE;
    end else begin
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

//--- tb/ppfs_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ppfs_top_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  port_a_out,
  input wire logic [7:0]  port_a_oe_n,
  input wire logic [7:0]  port_b_oe_n,
  input wire logic [7:0]  port_c_oe_n,
  input wire logic        halted,
  input wire logic        wake_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       ar_take;
  logic [7:0] ra;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ra = s_axi_rdata[7:0];
  AST_RST_PINS:
    assert property (disable iff (1'b0) !aresetn |=>
      (port_a_out & port_a_oe_n & port_b_oe_n & port_c_oe_n) == 8'hFF)
    else $error("pins not released to inputs after reset");
  AST_WAKE_CLR:
    assert property (!halted |=> !wake_request)
    else $error("wake request stands while running");
  AST_WAKE_HALT:
    assert property ($rose(wake_request) |-> $past(halted))
    else $error("wake request raised while running");
  AST_WAKE_HOLD:
    assert property (wake_request && halted |=> wake_request)
    else $error("wake request dropped while halted");
  AST_SEL_A_LOW:
    assert property (ar_take && s_axi_araddr == 8'h00 |=>
      s_axi_rvalid && (ra & ~ppfs_pkg::MASK_PORT_A_SELECT_LOW) == 8'h00)
    else $error("unused select bits read nonzero");
  AST_SEL_A_HIGH:
    assert property (ar_take && s_axi_araddr == 8'h04 |=>
      s_axi_rvalid && (ra & ~ppfs_pkg::MASK_PORT_A_SELECT_HIGH) == 8'h00)
    else $error("unused select bits read nonzero");
  AST_R_ANSWER:
    assert property (ar_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule
`default_nettype wire

//--- tb/ppfs_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppfs_pin_model (
  input  wire logic        aclk,
  input  wire logic        periph_on,
  input  wire logic [7:0]  ext_a,
  input  wire logic [7:0]  port_a_out,
  input  wire logic [7:0]  port_a_oe_n,
  input  wire logic [7:0]  port_b_out,
  input  wire logic [7:0]  port_b_oe_n,
  input  wire logic [7:0]  port_c_out,
  input  wire logic [7:0]  port_c_oe_n,
  output logic [7:0]       port_a_in,
  output logic [7:0]       port_b_in,
  output logic [7:0]       port_c_in,
  output logic             timer_compare_out,
  output logic             timer_compare_out_inverted,
  output logic             el_function,
  output logic [11:0]      lcd_segment
);
  logic [11:0] cnt = 12'h000;
  always @(posedge aclk) cnt <= periph_on ? cnt + 12'h001 : 12'h000;
  // Driver wins; released port A shows the bench level, B and C pull high
  assign port_a_in = (port_a_out & ~port_a_oe_n) | (ext_a & port_a_oe_n);
  assign port_b_in = port_b_out | port_b_oe_n;
  assign port_c_in = port_c_out | port_c_oe_n;
  // Timer sources move every cycle, el_function every two cycles and lcd_segment is the count xor A5A, so a stale latch value cannot pass for them
  assign timer_compare_out = cnt[0];
  assign timer_compare_out_inverted = periph_on & ~cnt[0];
  assign el_function = cnt[1];
  assign lcd_segment = cnt ^ 12'hA5A;
endmodule
`default_nettype wire

//--- tb/port_pin_function_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_select_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, halted = 1'b0, periph_on = 1'b0;
  logic [7:0]  ext_a = 8'hFF, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, timer_compare_out, timer_compare_out_inverted;
  logic        el_function, wake_request;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0]  port_a_in, port_a_out, port_a_oe_n, port_b_in, port_b_out;
  logic [7:0]  port_b_oe_n, port_c_in, port_c_out, port_c_oe_n;
  logic [11:0] lcd_segment;
  int          num_errors = 0, n_tests = 0, i, j;
  always #10 aclk = ~aclk;
  ppfs_top u_ppfs_top (.*);
  ppfs_pin_model u_ppfs_pin_model (.*);
  task tally_and_finish;
    $display("compares %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task timeout(input int k);
    if (k >= 50) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  // Ready is raised only after valid shows, so the hold checks get exercised
  task axi_write(input logic [7:0] a, input logic [31:0] d,
                 output logic [1:0] r);
    int   k;
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 50 && !(aw_done && w_done); k++) begin
      @(posedge aclk);
      if (s_axi_awready && !aw_done) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_done) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (; k < 50 && !s_axi_bvalid; k++) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    timeout(k);
  endtask
  task axi_read(input logic [7:0] a, output logic [31:0] d,
                output logic [1:0] r);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 50 && !(s_axi_arvalid && s_axi_arready); k++)
      @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    for (; k < 50 && !s_axi_rvalid; k++) @(posedge aclk);
    timeout(k);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
    check(rsp, ppfs_pkg::RESP_OKAY);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, rd, rsp);
    check(rd, exp);
  endtask
  task bitop(input logic [31:0] w);
    int k;
    wr(ppfs_pkg::ADDR_BIT_OP, w);
    for (k = 0; k < 50; k++) begin
      axi_read(ppfs_pkg::ADDR_STATUS, rd, rsp);
      if (rd[1] === 1'b0) break;
    end
    timeout(k);
  endtask
  task wait_wake(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge aclk);
      if (wake_request === 1'b1) seen = 1'b1;
    end
    check(seen, exp);
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0);
    for (i = 5; i < 11; i++) rd_chk(8'(4 * i), 32'hFF);
    @(negedge aclk);
    check({port_a_oe_n, port_b_oe_n, port_c_oe_n}, 24'hFFFFFF);
    @(posedge aclk);
    wr(8'h00, 32'hFF);
    wr(8'h04, 32'hFF);
    rd_chk(8'h00, 32'hCC);
    rd_chk(8'h04, 32'h03);
    periph_on <= 1'b1;
    for (i = 0; i < 2; i++) begin
      @(negedge aclk);
      check(port_a_oe_n, 8'hE5);
      check(port_a_out[3], timer_compare_out);
      check(port_a_out[1], el_function);
      check(port_a_out[4], timer_compare_out_inverted);
    end
    @(posedge aclk);
    periph_on <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    check(port_a_out, 8'hFF);
    for (i = 0; i < 4; i++) begin
      for (j = 2; j < 5; j++) wr(8'(4 * j), 32'({4{i[1:0]}}));
      periph_on <= 1'b1;
      @(negedge aclk);
      check(port_b_oe_n, i == 3 ? 8'h1F : 8'hFF);
      check(port_c_oe_n, i == 3 ? 8'h00 : 8'hFF);
      if (i == 3) begin
        check(port_b_out[7:5], lcd_segment[11:9]);
        check(port_c_out, lcd_segment[7:0]);
      end
      @(posedge aclk);
      periph_on <= 1'b0;
    end
    for (j = 2; j < 5; j++) wr(8'(4 * j), 32'h0);
    ext_a <= 8'h00;
    repeat (3) @(posedge aclk);
    rd_chk(ppfs_pkg::ADDR_PORT_A_DATA, 32'h00);
    wr(ppfs_pkg::ADDR_PORT_A_DIR, 32'h00);
    @(negedge aclk);
    check(port_a_oe_n, 8'h00);
    check(port_a_out, 8'hFF);
    @(posedge aclk);
    rd_chk(ppfs_pkg::ADDR_PORT_A_DATA, 32'hFF);
    // Upper pins read as inputs at level 0, so the write-back clears them
    wr(ppfs_pkg::ADDR_PORT_A_DIR, 32'hF0);
    bitop(32'h005);
    wr(ppfs_pkg::ADDR_PORT_A_DIR, 32'h00);
    rd_chk(ppfs_pkg::ADDR_PORT_A_DATA, 32'h0E);
    bitop(32'h175);
    rd_chk(ppfs_pkg::ADDR_PORT_A_DATA, 32'h8E);
    wr(ppfs_pkg::ADDR_PORT_A_DIR, 32'hFF);
    ext_a <= 8'hFF;
    wr(ppfs_pkg::ADDR_WAKE_ENABLE, 32'h01);
    ext_a <= 8'hFE;
    wait_wake(1'b0);
    ext_a <= 8'hFF;
    halted <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_a <= 8'hFE;
    wait_wake(1'b1);
    halted <= 1'b0;
    wr(8'h00, 32'hC0);
    wr(ppfs_pkg::ADDR_WAKE_ENABLE, 32'h09);
    ext_a <= 8'hFF;
    periph_on <= 1'b1;
    halted <= 1'b1;
    wait_wake(1'b0);
    ext_a <= 8'hFE;
    wait_wake(1'b1);
    halted <= 1'b0;
    axi_read(8'h3C, rd, rsp);
    check(rsp, ppfs_pkg::RESP_SLVERR);
    check(rd, 32'h0);
    axi_write(8'h3C, 32'hFF, rsp);
    check(rsp, ppfs_pkg::RESP_SLVERR);
    tally_and_finish();
  end
endmodule
bind ppfs_top ppfs_top_chk u_ppfs_top_chk (.*);
`default_nettype wire
